// >>> core/bsx_pkg.sv
package bsx_pkg;

  // Widths of the program counter, the I/O address and the register port.
  localparam int PC_W = 16;
  localparam int IO_AW = 5;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 16;

  // Positions of the flags inside the status flags register.
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // Register port offsets.
  localparam logic [BUS_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [BUS_AW-1:0] REG_PC = 8'h01;
  localparam logic [BUS_AW-1:0] REG_FLAGS = 8'h02;
  localparam logic [BUS_AW-1:0] REG_RETIRED = 8'h03;

  // Control register fields and reset values.
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;

  // Program counter steps for fall through and for skipping one or two words.
  localparam logic [PC_W-1:0] PC_STEP1 = 16'h0001;
  localparam logic [PC_W-1:0] PC_STEP2 = 16'h0002;
  localparam logic [PC_W-1:0] PC_STEP3 = 16'h0003;

  // Operations handled by this execution block.
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_SKIP_IO_SET = 5'h01,
    OP_BR_FLAG_SET = 5'h02,
    OP_BR_FLAG_CLR = 5'h03,
    OP_BR_EQ = 5'h04,
    OP_BR_NE = 5'h05,
    OP_BR_CS = 5'h06,
    OP_BR_CC = 5'h07,
    OP_BR_SH = 5'h08,
    OP_BR_LO = 5'h09,
    OP_BR_MINUS = 5'h0A,
    OP_BR_PLUS = 5'h0B,
    OP_BR_SGE = 5'h0C,
    OP_BR_SLT = 5'h0D,
    OP_BR_HS = 5'h0E,
    OP_BR_HC = 5'h0F,
    OP_BR_TS = 5'h10,
    OP_BR_TC = 5'h11,
    OP_BR_VS = 5'h12,
    OP_BR_VC = 5'h13,
    OP_BR_IE = 5'h14,
    OP_BR_ID = 5'h15,
    OP_SET_IO = 5'h16,
    OP_CLR_IO = 5'h17,
    OP_LSL = 5'h18,
    OP_LSR = 5'h19,
    OP_ROL = 5'h1A
  } bsx_op_t;

  // Decoded instruction handed over by the decode stage.
  typedef struct packed {
    bsx_op_t op;
    logic [2:0] bit_sel;
    logic [IO_AW-1:0] io_addr;
    logic [6:0] k;
    logic next_two_word;
  } bsx_instr_t;

  // One-hot sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT1 = 3'b010,
    ST_WAIT2 = 3'b100
  } bsx_state_t;

endpackage : bsx_pkg

// >>> core/bsx_cond.sv
`timescale 1ns/1ps
module bsx_cond
  import bsx_pkg::*;
(
  // Operation and selectors.
  input wire bsx_op_t op,
  input wire logic [2:0] flag_sel,
  // Current status flags.
  input wire logic [7:0] flags,
  // Outcome.
  output logic is_branch,
  output logic take
);

  // Decides whether an operation is a branch and whether its condition holds.
  always_comb begin
    is_branch = 1'b1;
    take = 1'b0;
    case (op)
      OP_BR_FLAG_SET: take = flags[flag_sel];
      OP_BR_FLAG_CLR: take = ~flags[flag_sel];
      OP_BR_EQ: take = flags[FLG_Z];
      OP_BR_NE: take = ~flags[FLG_Z];
      OP_BR_CS, OP_BR_LO: take = flags[FLG_C];
      OP_BR_CC, OP_BR_SH: take = ~flags[FLG_C];
      OP_BR_MINUS: take = flags[FLG_N];
      OP_BR_PLUS: take = ~flags[FLG_N];
      OP_BR_SGE: take = ~(flags[FLG_N] ^ flags[FLG_V]);
      OP_BR_SLT: take = flags[FLG_N] ^ flags[FLG_V];
      OP_BR_HS: take = flags[FLG_H];
      OP_BR_HC: take = ~flags[FLG_H];
      OP_BR_TS: take = flags[FLG_T];
      OP_BR_TC: take = ~flags[FLG_T];
      OP_BR_VS: take = flags[FLG_V];
      OP_BR_VC: take = ~flags[FLG_V];
      OP_BR_IE: take = flags[FLG_I];
      OP_BR_ID: take = ~flags[FLG_I];
      default: is_branch = 1'b0;
    endcase
  end

endmodule : bsx_cond

// >>> core/bsx_shift.sv
`timescale 1ns/1ps
module bsx_shift
  import bsx_pkg::*;
(
  // Operation and operand.
  input wire bsx_op_t op,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  // Result and new flags.
  output logic is_shift,
  output logic [7:0] result,
  output logic c_out,
  output logic z_out,
  output logic n_out,
  output logic v_out
);

  // Shifts one place, filling with zero or the old carry.
  always_comb begin
    is_shift = 1'b1;
    result = operand;
    c_out = carry_in;
    case (op)
      OP_LSL: begin
        result = {operand[6:0], 1'b0};
        c_out = operand[7];
      end
      OP_LSR: begin
        result = {1'b0, operand[7:1]};
        c_out = operand[0];
      end
      OP_ROL: begin
        result = {operand[6:0], carry_in};
        c_out = operand[7];
      end
      default: is_shift = 1'b0;
    endcase
  end

  // Zero and negative follow the result; overflow is negative xor carry.
  assign z_out = (result == 8'h00);
  assign n_out = result[7];
  assign v_out = result[7] ^ c_out;

endmodule : bsx_shift

// >>> core/bsx_exec.sv
`timescale 1ns/1ps
module bsx_exec
  import bsx_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // Instruction issue.
  input wire logic INSTR_VALID,
  input wire bsx_instr_t INSTR,
  output logic READY,
  output logic DONE,
  // Data register operand and result.
  input wire logic [7:0] RD_VALUE,
  output logic [7:0] RD_RESULT,
  output logic RD_WE,
  // I/O register space.
  output logic [IO_AW-1:0] IO_ADDR,
  input wire logic [7:0] IO_RDATA,
  output logic IO_WR,
  output logic [7:0] IO_WDATA,
  // Architectural state.
  output logic [PC_W-1:0] PC,
  output logic [7:0] FLAGS,
  // Register port.
  input wire logic [BUS_AW-1:0] BUS_ADDR,
  input wire logic [BUS_DW-1:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [BUS_DW-1:0] BUS_RDATA
);

  bsx_state_t state_q;
  bsx_state_t state_d;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pend_pc_q;
  logic [7:0] flags_q;
  logic [7:0] ctrl_q;
  logic [BUS_DW-1:0] retired_q;
  logic [IO_AW-1:0] io_addr_q;
  logic io_wr_pend_q;
  logic [7:0] io_wdata_q;
  logic [7:0] rd_result_q;
  logic rd_we_q;
  logic [BUS_DW-1:0] bus_rdata_q;
  logic fire;
  logic is_branch;
  logic take;
  logic is_shift;
  logic [7:0] sh_result;
  logic sh_c;
  logic sh_z;
  logic sh_n;
  logic sh_v;
  logic io_bit;
  logic [7:0] bit_mask;
  logic [PC_W-1:0] k_ext;
  logic [PC_W-1:0] tgt_pc;
  logic [1:0] cycles;

  // Condition evaluation for all relative branches.
  bsx_cond u_cond (
    .op(INSTR.op),
    .flag_sel(INSTR.bit_sel),
    .flags(flags_q),
    .is_branch(is_branch),
    .take(take)
  );

  // One-place shifter for the shift and rotate operations.
  bsx_shift u_shift (
    .op(INSTR.op),
    .operand(RD_VALUE),
    .carry_in(flags_q[FLG_C]),
    .is_shift(is_shift),
    .result(sh_result),
    .c_out(sh_c),
    .z_out(sh_z),
    .n_out(sh_n),
    .v_out(sh_v)
  );

  // Accept only while idle and software lets the block run.
  assign READY = (state_q == ST_IDLE) && ctrl_q[CTRL_RUN_BIT];
  assign fire = INSTR_VALID && READY;

  // The I/O address follows the new instruction, then the held one during write back.
  assign IO_ADDR = (state_q == ST_IDLE) ? INSTR.io_addr : io_addr_q;
  assign io_bit = IO_RDATA[INSTR.bit_sel];
  assign bit_mask = 8'h01 << INSTR.bit_sel;

  // Displacement sign extended to the program counter width.
  assign k_ext = {{(PC_W - 7){INSTR.k[6]}}, INSTR.k};

  // Target program counter and cost in cycles of the offered instruction.
  always_comb begin
    tgt_pc = pc_q + PC_STEP1;
    cycles = 2'h1;
    if (is_branch) begin
      if (take) begin
        tgt_pc = pc_q + k_ext + PC_STEP1;
        cycles = 2'h2;
      end
    end else if (INSTR.op == OP_SKIP_IO_SET) begin
      if (io_bit) begin
        tgt_pc = pc_q + (INSTR.next_two_word ? PC_STEP3 : PC_STEP2);
        cycles = INSTR.next_two_word ? 2'h3 : 2'h2;
      end
    end else if (INSTR.op == OP_SET_IO || INSTR.op == OP_CLR_IO) begin
      cycles = 2'h2;
    end
  end

  // Sequencer that stretches an instruction to its cycle count.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (fire && cycles == 2'h2) begin
          state_d = ST_WAIT1;
        end else if (fire && cycles == 2'h3) begin
          state_d = ST_WAIT2;
        end
      end
      ST_WAIT2: state_d = ST_WAIT1;
      ST_WAIT1: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Done marks the last cycle of every instruction, whatever its length.
  assign DONE = (fire && cycles == 2'h1) || (state_q == ST_WAIT1);

  // Sequencer state register.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Program counter: one-cycle work updates now, longer work at its last cycle.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pc_q <= PC_RST;
      pend_pc_q <= PC_RST;
    end else begin
      if (fire) begin
        pend_pc_q <= tgt_pc;
      end
      if (fire && cycles == 2'h1) begin
        pc_q <= tgt_pc;
      end else if (state_q == ST_WAIT1) begin
        pc_q <= pend_pc_q;
      end else if (BUS_WR && BUS_ADDR == REG_PC && state_q == ST_IDLE) begin
        pc_q <= BUS_WDATA[PC_W-1:0];
      end
    end
  end

  // Read-modify-write of one I/O bit, written back in the second cycle.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      io_addr_q <= '0;
      io_wr_pend_q <= 1'b0;
      io_wdata_q <= 8'h00;
    end else begin
      io_wr_pend_q <= 1'b0;
      if (fire && INSTR.op == OP_SET_IO) begin
        io_addr_q <= INSTR.io_addr;
        io_wr_pend_q <= 1'b1;
        io_wdata_q <= IO_RDATA | bit_mask;
      end else if (fire && INSTR.op == OP_CLR_IO) begin
        io_addr_q <= INSTR.io_addr;
        io_wr_pend_q <= 1'b1;
        io_wdata_q <= IO_RDATA & ~bit_mask;
      end
    end
  end

  assign IO_WR = io_wr_pend_q;
  assign IO_WDATA = io_wdata_q;

  // Shift result goes back to the data register one cycle after issue.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_result_q <= 8'h00;
      rd_we_q <= 1'b0;
    end else begin
      rd_we_q <= fire && is_shift;
      if (fire && is_shift) begin
        rd_result_q <= sh_result;
      end
    end
  end

  // Only shifts and register port writes touch the flags; branches, skips and bit writes leave them alone.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags_q <= FLAGS_RST;
    end else if (fire && is_shift) begin
      flags_q[FLG_C] <= sh_c;
      flags_q[FLG_Z] <= sh_z;
      flags_q[FLG_N] <= sh_n;
      flags_q[FLG_V] <= sh_v;
    end else if (BUS_WR && BUS_ADDR == REG_FLAGS) begin
      flags_q <= BUS_WDATA[7:0];
    end
  end

  // Control register and a count of finished instructions.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= CTRL_RST;
      retired_q <= '0;
    end else begin
      if (BUS_WR && BUS_ADDR == REG_CTRL) begin
        ctrl_q <= BUS_WDATA[7:0];
      end
      if (BUS_WR && BUS_ADDR == REG_RETIRED) begin
        retired_q <= '0;
      end else if (DONE) begin
        retired_q <= retired_q + 16'h0001;
      end
    end
  end

  // Register port read data, valid the cycle after the read strobe.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_rdata_q <= '0;
    end else if (BUS_RD) begin
      if (BUS_ADDR == REG_CTRL) begin
        bus_rdata_q <= {8'h00, ctrl_q};
      end else if (BUS_ADDR == REG_PC) begin
        bus_rdata_q <= pc_q;
      end else if (BUS_ADDR == REG_FLAGS) begin
        bus_rdata_q <= {8'h00, flags_q};
      end else if (BUS_ADDR == REG_RETIRED) begin
        bus_rdata_q <= retired_q;
      end else begin
        bus_rdata_q <= '0;
      end
    end else begin
      bus_rdata_q <= '0;
    end
  end

  assign RD_RESULT = rd_result_q;
  assign RD_WE = rd_we_q;
  assign PC = pc_q;
  assign FLAGS = flags_q;
  assign BUS_RDATA = bus_rdata_q;

  // Checks on the executed behaviour.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  a_skip_three_cyc: assert property (fire && INSTR.op == OP_SKIP_IO_SET && io_bit &&
      INSTR.next_two_word |-> ##1 state_q == ST_WAIT2 ##1 DONE
      ##1 pc_q == $past(pc_q, 3) + PC_STEP3)
    else $error("Skip over a two-word instruction went wrong.");
  a_skip_keeps_flags: assert property (fire && INSTR.op == OP_SKIP_IO_SET &&
      !(BUS_WR && BUS_ADDR == REG_FLAGS) |=> flags_q == $past(flags_q))
    else $error("Skip changed the flags.");
  a_branch_taken_pc: assert property (fire && is_branch && take &&
      !(BUS_WR && BUS_ADDR == REG_FLAGS) |-> !DONE ##1 DONE
      ##1 pc_q == $past(pc_q, 2) + $past(k_ext, 2) + PC_STEP1)
    else $error("Taken branch target or timing wrong.");
  a_branch_fall_thru: assert property (fire && is_branch && !take |-> DONE
      ##1 (pc_q == $past(pc_q) + PC_STEP1 && state_q == ST_IDLE))
    else $error("Untaken branch did not fall through in one cycle.");
  a_carry_cond: assert property (fire && (INSTR.op == OP_BR_CC || INSTR.op == OP_BR_SH)
      |-> take == !flags_q[FLG_C])
    else $error("Carry-clear condition wrong.");
  a_signed_ge: assert property (fire && INSTR.op == OP_BR_SGE
      |-> take == !(flags_q[FLG_N] ^ flags_q[FLG_V]))
    else $error("Signed greater-or-equal condition wrong.");
  a_signed_lt: assert property (fire && INSTR.op == OP_BR_SLT
      |-> take == (flags_q[FLG_N] ^ flags_q[FLG_V]))
    else $error("Signed less-than condition wrong.");
  a_flag_tests: assert property (fire && take |->
      !(INSTR.op == OP_BR_HS && !flags_q[FLG_H]) && !(INSTR.op == OP_BR_TC && flags_q[FLG_T])
      && !(INSTR.op == OP_BR_VS && !flags_q[FLG_V]) && !(INSTR.op == OP_BR_ID && flags_q[FLG_I]))
    else $error("Flag-test branch taken on the wrong flag value.");
  a_set_io_write: assert property (fire && INSTR.op == OP_SET_IO |=> IO_WR && DONE
      && IO_WDATA == ($past(IO_RDATA) | $past(bit_mask)) ##1 !IO_WR)
    else $error("Set-bit write back wrong.");
  a_clr_io_write: assert property (fire && INSTR.op == OP_CLR_IO |=> IO_WR
      && IO_WDATA == ($past(IO_RDATA) & ~$past(bit_mask)))
    else $error("Clear-bit write back wrong.");
  a_rotate_carry: assert property (fire && INSTR.op == OP_ROL |=> RD_WE
      && RD_RESULT == {$past(RD_VALUE[6:0]), $past(flags_q[FLG_C])}
      && flags_q[FLG_C] == $past(RD_VALUE[7]))
    else $error("Rotate through carry wrong.");

  c_skip_two_word: cover property (fire && INSTR.op == OP_SKIP_IO_SET && cycles == 2'h3);
  c_branch_taken: cover property (fire && is_branch && take);
  c_set_io: cover property (fire && INSTR.op == OP_SET_IO);
  c_rotate: cover property (fire && INSTR.op == OP_ROL);

endmodule : bsx_exec

// >>> bench/bsx_exec_tb.sv
`timescale 1ns/1ps
`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end
module bsx_exec_tb
  import bsx_pkg::*;
;

  // Stimulus and observed signals.
  logic SYS_CLK, ARST_N, INSTR_VALID, READY, DONE, RD_WE, IO_WR, BUS_WR, BUS_RD;
  bsx_instr_t INSTR;
  logic [7:0] RD_VALUE, RD_RESULT, IO_RDATA, IO_WDATA, FLAGS;
  logic [IO_AW-1:0] IO_ADDR;
  logic [PC_W-1:0] PC;
  logic [BUS_AW-1:0] BUS_ADDR;
  logic [BUS_DW-1:0] BUS_WDATA, BUS_RDATA;
  logic [7:0] io_mem [32];
  logic io_wr_seen;
  int err_count = 0;
  int checked = 0;

  bsx_exec dut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .READY(READY), .DONE(DONE), .RD_VALUE(RD_VALUE), .RD_RESULT(RD_RESULT), .RD_WE(RD_WE),
    .IO_ADDR(IO_ADDR), .IO_RDATA(IO_RDATA), .IO_WR(IO_WR), .IO_WDATA(IO_WDATA), .PC(PC),
    .FLAGS(FLAGS), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR),
    .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA));

  // The I/O space answers combinationally and takes writes on the clock edge.
  assign IO_RDATA = io_mem[IO_ADDR];
  always @(posedge SYS_CLK) begin
    if (IO_WR === 1'b1) io_mem[IO_ADDR] <= IO_WDATA;
  end

  // A 200 MHz clock.
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // One register write cycle.
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    BUS_WR <= 1'b1;
    BUS_ADDR <= a;
    BUS_WDATA <= d;
    @(posedge SYS_CLK);
    BUS_WR <= 1'b0;
  endtask : bus_wr

  // One register read cycle; the data are taken in the following cycle.
  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge SYS_CLK);
    BUS_RD <= 1'b1;
    BUS_ADDR <= a;
    @(posedge SYS_CLK);
    BUS_RD <= 1'b0;
    @(negedge SYS_CLK);
    d = BUS_RDATA;
  endtask : bus_rd

  // Issues one instruction and counts its cycles up to and including the DONE cycle.
  task automatic run(input bsx_instr_t ins, output int cyc);
    @(posedge SYS_CLK);
    INSTR_VALID <= 1'b1;
    INSTR <= ins;
    cyc = 1;
    @(negedge SYS_CLK);
    while (DONE !== 1'b1 && cyc < 5) begin
      @(posedge SYS_CLK);
      INSTR_VALID <= 1'b0;
      cyc++;
      @(negedge SYS_CLK);
    end
    io_wr_seen = IO_WR;
    @(posedge SYS_CLK);
    INSTR_VALID <= 1'b0;
    #1;
  endtask : run

  function automatic bsx_instr_t mk(bsx_op_t op, logic [2:0] b, logic [6:0] k, logic tw);
    mk = '{op, b, 5'h05, k, tw};
  endfunction : mk

  // Runs one instruction from PC 0x0100 and judges cost, new PC and flags.
  task automatic exec_chk(input bsx_instr_t ins, input logic [7:0] f, input int cyc_exp,
                          input logic [15:0] pc_exp, input logic [7:0] f_exp);
    int cyc;
    bus_wr(REG_FLAGS, {8'h00, f});
    bus_wr(REG_PC, 16'h0100);
    run(ins, cyc);
    `CHK("cycles", cyc_exp, cyc)
    `CHK("pc", pc_exp, PC)
    `CHK("flags", f_exp, FLAGS)
  endtask : exec_chk

  // Branch on one flag, with the flag at each level and all other flags opposite.
  task automatic br_flag(input bsx_op_t op, input int bit_i, input logic pol);
    logic [7:0] f;
    logic [6:0] k;
    logic taken;
    for (int v = 0; v < 2; v++) begin
      f = v[0] ? (8'h01 << bit_i) : ~(8'h01 << bit_i);
      k = v[0] ? 7'h40 : 7'h3F;
      taken = (v[0] == pol);
      exec_chk(mk(op, bit_i[2:0], k, 1'b0), f, taken ? 2 : 1,
               taken ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101, f);
    end
  endtask : br_flag

  // Skip on each I/O bit, over a one-word and a two-word instruction.
  task automatic skip_test;
    int c;
    for (int b = 0; b < 8; b++) begin
      for (int tw = 0; tw < 2; tw++) begin
        io_mem[5] = 8'hA5;
        c = io_mem[5][b] ? (tw ? 3 : 2) : 1;
        exec_chk(mk(OP_SKIP_IO_SET, b[2:0], 7'h00, tw[0]), 8'h5A, c,
                 16'h0100 + c[15:0], 8'h5A);
      end
    end
  endtask : skip_test

  // Sets and clears each I/O bit, leaving its neighbours and the flags alone.
  task automatic io_bit_test;
    for (int b = 0; b < 8; b++) begin
      io_mem[5] = 8'h5A;
      exec_chk(mk(OP_SET_IO, b[2:0], 7'h00, 1'b0), 8'hC3, 2, 16'h0101, 8'hC3);
      `CHK("io set", 8'h5A | (8'h01 << b), io_mem[5])
      `CHK("io write", 1'b1, io_wr_seen)
      exec_chk(mk(OP_CLR_IO, b[2:0], 7'h00, 1'b0), 8'h3C, 2, 16'h0101, 8'h3C);
      `CHK("io clear", 8'h5A & ~(8'h01 << b), io_mem[5])
      `CHK("io clear write", 1'b1, io_wr_seen)
    end
  endtask : io_bit_test

  // Shifts and rotate against a reference worked out here.
  task automatic shift_test;
    logic [7:0] vals [5] = '{8'h81, 8'h01, 8'h80, 8'h40, 8'h00};
    bsx_op_t ops [3] = '{OP_LSL, OP_LSR, OP_ROL};
    logic [7:0] a, r, f;
    logic c;
    for (int o = 0; o < 3; o++) begin
      for (int i = 0; i < 10; i++) begin
        a = vals[i % 5];
        f = {7'h53, i >= 5};
        r = (o == 1) ? {1'b0, a[7:1]} : {a[6:0], (o == 2) ? f[0] : 1'b0};
        c = (o == 1) ? a[0] : a[7];
        RD_VALUE <= a;
        exec_chk(mk(ops[o], 3'h0, 7'h00, 1'b0), f, 1, 16'h0101,
                 {f[7:4], r[7] ^ c, r[7], r == 8'h00, c});
        `CHK("shift result", r, RD_RESULT)
        `CHK("shift write", 1'b1, RD_WE)
      end
    end
  endtask : shift_test

  // Watchdog against a hang.
  initial begin
    #50000;
    err_count++;
    finish_test();
  end

  // Main sequence.
  initial begin
    logic [15:0] d;
    ARST_N = 1'b0;
    INSTR_VALID = 1'b0;
    INSTR = '0;
    RD_VALUE = 8'h00;
    BUS_ADDR = 8'h00;
    BUS_WDATA = 16'h0000;
    BUS_WR = 1'b0;
    BUS_RD = 1'b0;
    for (int i = 0; i < 32; i++) io_mem[i] = 8'h00;
    repeat (8) @(posedge SYS_CLK);
    `CHK("reset pc", PC_RST, PC)
    `CHK("reset flags", FLAGS_RST, FLAGS)
    ARST_N <= 1'b1;
    bus_rd(REG_CTRL, d);
    `CHK("ctrl read", {8'h00, CTRL_RST}, d)
    bus_rd(8'h10, d);
    `CHK("unmapped read", 16'h0000, d)
    bus_wr(REG_CTRL, 16'h0000);
    @(negedge SYS_CLK);
    `CHK("ready stopped", 1'b0, READY)
    bus_wr(REG_CTRL, 16'h0001);
    for (int s = 0; s < 8; s++) begin
      br_flag(OP_BR_FLAG_SET, s, 1'b1);
      br_flag(OP_BR_FLAG_CLR, s, 1'b0);
    end
    br_flag(OP_BR_EQ, FLG_Z, 1'b1);
    br_flag(OP_BR_NE, FLG_Z, 1'b0);
    br_flag(OP_BR_CS, FLG_C, 1'b1);
    br_flag(OP_BR_CC, FLG_C, 1'b0);
    br_flag(OP_BR_SH, FLG_C, 1'b0);
    br_flag(OP_BR_LO, FLG_C, 1'b1);
    br_flag(OP_BR_MINUS, FLG_N, 1'b1);
    br_flag(OP_BR_PLUS, FLG_N, 1'b0);
    br_flag(OP_BR_HS, FLG_H, 1'b1);
    br_flag(OP_BR_HC, FLG_H, 1'b0);
    br_flag(OP_BR_TS, FLG_T, 1'b1);
    br_flag(OP_BR_TC, FLG_T, 1'b0);
    br_flag(OP_BR_VS, FLG_V, 1'b1);
    br_flag(OP_BR_VC, FLG_V, 1'b0);
    br_flag(OP_BR_IE, FLG_I, 1'b1);
    br_flag(OP_BR_ID, FLG_I, 1'b0);
    for (int nv = 0; nv < 4; nv++) begin
      exec_chk(mk(OP_BR_SGE, 3'h0, 7'h7E, 1'b0), {4'h0, nv[1:0], 2'b00},
               (nv == 0 || nv == 3) ? 2 : 1,
               (nv == 0 || nv == 3) ? 16'h00FF : 16'h0101, {4'h0, nv[1:0], 2'b00});
      exec_chk(mk(OP_BR_SLT, 3'h0, 7'h05, 1'b0), {4'h0, nv[1:0], 2'b00},
               (nv == 1 || nv == 2) ? 2 : 1,
               (nv == 1 || nv == 2) ? 16'h0106 : 16'h0101, {4'h0, nv[1:0], 2'b00});
    end
    skip_test();
    io_bit_test();
    shift_test();
    finish_test();
  end
endmodule : bsx_exec_tb
